/* File: logic/bmu_top.sv */
// breakpoint match unit: debug registers, matching and exception requests
`timescale 1ns/100ps
`default_nettype none
module bmu_top #(
  parameter bit EIGHT_BYTE = 1'b0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // debug register move port
  input wire logic [2:0] dr_sel_i,
  input wire logic dr_wr_i,
  input wire logic dr_rd_i,
  input wire logic [31:0] dr_wdata_i,
  output logic [31:0] dr_rdata_o,
  output logic dr_undef_o,
  // core mode flags
  input wire logic ext_interp_flag_i,
  input wire logic resume_flag_i,
  input wire logic step_trap_flag_i,
  // instruction fetch
  input wire logic fetch_valid_i,
  input wire logic [bmu_pkg::ADDR_W-1:0] fetch_addr_i,
  // data access
  input wire logic data_valid_i,
  input wire logic data_write_i,
  input wire logic [bmu_pkg::ADDR_W-1:0] data_addr_i,
  input wire logic [bmu_pkg::NB_W-1:0] data_nbytes_i,
  // io access
  input wire logic io_valid_i,
  input wire logic [bmu_pkg::IO_W-1:0] io_port_i,
  input wire logic [bmu_pkg::NB_W-1:0] io_nbytes_i,
  // core events
  input wire logic mov_dr_i,
  input wire logic insn_done_i,
  input wire logic task_switch_i,
  input wire logic task_trap_i,
  input wire logic handler_entry_i,
  // exception requests and state
  output logic [bmu_pkg::NBRK-1:0] brk_hit_flags_o,
  output logic fault_req_o,
  output logic trap_req_o,
  output logic [31:0] brk_status_word_o,
  output logic [31:0] brk_control_word_o
);
  import bmu_pkg::*;

  logic [ADDR_W-1:0] brk_addr_regs [NBRK];
  logic [31:0] brk_status_word;
  logic [31:0] brk_control_word;
  logic [31:0] next_status;
  logic [31:0] next_control;
  logic [NBRK-1:0] hit;
  logic [NBRK-1:0] armed;
  logic [NBRK-1:0] is_exec;
  logic guard;
  logic reg_hit;
  logic step_hit;
  logic task_hit;
  logic exc;
  logic [2:0] sel;
  logic acc_ok;
  logic wr_ok;
  logic rd_ok;

  // register 4 and 5 fold onto 6 and 7 unless extensions are on
  function automatic logic [2:0] map_sel(logic [2:0] s, logic ext);
    if (!ext && (s == SEL_ALIAS_ST || s == SEL_ALIAS_CT)) begin
      return s + 3'h2;
    end
    return s;
  endfunction

  assign sel = map_sel(dr_sel_i, ext_interp_flag_i);
  assign dr_undef_o = (dr_wr_i || dr_rd_i) && ext_interp_flag_i
                      && (dr_sel_i == SEL_ALIAS_ST
                          || dr_sel_i == SEL_ALIAS_CT);
  assign guard = brk_control_word[CT_GUARD];
  // a guarded move never executes; the core takes the fault first
  assign acc_ok = !dr_undef_o && !guard;
  assign wr_ok = dr_wr_i && acc_ok;
  assign rd_ok = dr_rd_i && acc_ok;

  // four comparators side by side, all answer in the access cycle
  for (genvar n = 0; n < NBRK; n++) begin : g_cmp
    bmu_cmp #(
      .AW(ADDR_W),
      .EIGHT(EIGHT_BYTE)
    ) u_cmp (
      .base_i(brk_addr_regs[n]),
      .kind_i(kind_of(brk_control_word, n)),
      .span_i(span_of(brk_control_word, n)),
      .ext_i(ext_interp_flag_i),
      .resume_i(resume_flag_i),
      .fetch_v_i(fetch_valid_i),
      .fetch_addr_i(fetch_addr_i),
      .data_v_i(data_valid_i),
      .data_wr_i(data_write_i),
      .data_addr_i(data_addr_i),
      .data_nb_i(data_nbytes_i),
      .io_v_i(io_valid_i),
      .io_port_i(io_port_i),
      .io_nb_i(io_nbytes_i),
      .hit_o(hit[n])
    );
    assign armed[n] = brk_control_word[2*n]
                      | brk_control_word[2*n+1];
    assign is_exec[n] = kind_of(brk_control_word, n) == KIND_EXEC;
  end

  assign reg_hit = guard && mov_dr_i;
  assign step_hit = step_trap_flag_i && insn_done_i;
  assign task_hit = task_switch_i && task_trap_i;

  // exact flags 8 and 9 are stored but steer nothing
  assign fault_req_o = |(hit & armed & is_exec) || reg_hit;
  assign trap_req_o = |(hit & armed & ~is_exec) || step_hit
                      || task_hit;
  assign exc = fault_req_o || trap_req_o;
  assign brk_hit_flags_o = hit;

  // exception sampling wins over a software write in the same cycle
  always_comb begin
    next_status = brk_status_word;
    if (wr_ok && sel == SEL_STATUS) begin
      next_status = dr_wdata_i & ST_WMASK;
    end
    if (exc) begin
      // hits of unarmed breakpoints are recorded too
      next_status[ST_HIT_LSB +: NBRK] = hit;
      next_status[ST_REGACC] = next_status[ST_REGACC] | reg_hit;
      next_status[ST_STEP] = next_status[ST_STEP] | step_hit;
      next_status[ST_TASK] = next_status[ST_TASK] | task_hit;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      brk_status_word <= ST_RESET;
    end else begin
      brk_status_word <= next_status;
    end
  end

  // hardware clears win over a software write in the same cycle
  always_comb begin
    next_control = brk_control_word;
    if (wr_ok && sel == SEL_CTRL) begin
      next_control = dr_wdata_i & CT_WMASK;
    end
    if (task_switch_i) begin
      next_control = next_control & ~CT_LOCAL_MASK;
    end
    if (handler_entry_i) begin
      next_control[CT_GUARD] = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      brk_control_word <= CT_RESET;
    end else begin
      brk_control_word <= next_control;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NBRK; i++) begin
        brk_addr_regs[i] <= ADDR_RESET;
      end
    end else if (wr_ok && sel < 3'(NBRK)) begin
      brk_addr_regs[sel[1:0]] <= dr_wdata_i;
    end
  end

  // read data are held until the next accepted read
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dr_rdata_o <= 32'h00000000;
    end else if (rd_ok) begin
      if (sel == SEL_STATUS) begin
        dr_rdata_o <= brk_status_word;
      end else if (sel == SEL_CTRL) begin
        dr_rdata_o <= brk_control_word;
      end else begin
        dr_rdata_o <= brk_addr_regs[sel[1:0]];
      end
    end
  end

  assign brk_status_word_o = brk_status_word;
  assign brk_control_word_o = brk_control_word;

  a_status_hold: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !exc && !(wr_ok && sel == SEL_STATUS)
    |=> $stable(brk_status_word))
    else $error("status word changed without exception");

  a_hit_sample: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    exc |=> brk_status_word[3:0] == $past(hit))
    else $error("hit flags not sampled on exception");

  a_guard_fault: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    guard && mov_dr_i
    |-> fault_req_o ##1 brk_status_word[ST_REGACC])
    else $error("guarded move did not fault with access flag");

  a_regacc_only: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !guard && !(wr_ok && sel == SEL_STATUS)
    && !brk_status_word[ST_REGACC]
    |=> !brk_status_word[ST_REGACC])
    else $error("access flag set while guard off");

  a_step_flag: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    step_trap_flag_i && insn_done_i
    |-> trap_req_o ##1 brk_status_word[ST_STEP])
    else $error("single step not reported");

  a_task_flag: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    task_switch_i && task_trap_i
    |-> trap_req_o ##1 brk_status_word[ST_TASK])
    else $error("task trap not reported");

  a_no_self_clear: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !(wr_ok && sel == SEL_STATUS)
    |=> (brk_status_word[15:13] & $past(brk_status_word[15:13]))
        == $past(brk_status_word[15:13]))
    else $error("device cleared a high status bit");

  a_local_clear: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    task_switch_i
    |=> (brk_control_word & CT_LOCAL_MASK) == 32'h00000000)
    else $error("per-task arm bits survived task switch");

  a_global_keep: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    task_switch_i && !(wr_ok && sel == SEL_CTRL)
    |=> (brk_control_word[7:1] & 7'h55)
        == ($past(brk_control_word[7:1]) & 7'h55))
    else $error("all-task arm bits changed on task switch");

  a_guard_clear: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    handler_entry_i |=> !guard)
    else $error("guard flag not cleared on handler entry");

  a_armed_trap: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    |(hit & armed & ~is_exec) |-> trap_req_o)
    else $error("armed data hit raised no trap");

  a_resume_quiet: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    resume_flag_i && !(guard && mov_dr_i) |-> !fault_req_o)
    else $error("instruction fault under resume flag");

  a_unarmed_idle: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    armed == 4'h0 && !step_hit && !task_hit && !reg_hit
    |-> !fault_req_o && !trap_req_o)
    else $error("request without an armed cause");
endmodule
`default_nettype wire

/* File: logic/bmu_pkg.sv */
// breakpoint match unit: shared constants, types and field decoders
package bmu_pkg;
  localparam int ADDR_W = 32;
  localparam int IO_W = 16;
  localparam int NBRK = 4;
  localparam int NB_W = 4;
  // debug register numbers on the move port
  localparam logic [2:0] SEL_ALIAS_ST = 3'h4;
  localparam logic [2:0] SEL_ALIAS_CT = 3'h5;
  localparam logic [2:0] SEL_STATUS = 3'h6;
  localparam logic [2:0] SEL_CTRL = 3'h7;
  // status word fields
  localparam int ST_HIT_LSB = 0;
  localparam int ST_REGACC = 13;
  localparam int ST_STEP = 14;
  localparam int ST_TASK = 15;
  localparam logic [31:0] ST_WMASK = 32'h0000E00F;
  localparam logic [31:0] ST_RESET = 32'h00000000;
  // control word fields
  localparam int CT_GUARD = 13;
  localparam int CT_KIND_LSB = 16;
  localparam int CT_SIZE_LSB = 18;
  localparam int CT_STRIDE = 4;
  localparam logic [31:0] CT_WMASK = 32'hFFFF23FF;
  localparam logic [31:0] CT_RESET = 32'h00000000;
  localparam logic [31:0] CT_LOCAL_MASK = 32'h00000055;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    KIND_EXEC = 2'b00,
    KIND_WR = 2'b01,
    KIND_IO = 2'b10,
    KIND_RW = 2'b11
  } bmu_kind_t;

  typedef enum logic [1:0] {
    SPAN_1 = 2'b00,
    SPAN_2 = 2'b01,
    SPAN_8 = 2'b10,
    SPAN_4 = 2'b11
  } bmu_span_t;

  function automatic bmu_kind_t kind_of(logic [31:0] c, int n);
    return bmu_kind_t'(c[CT_KIND_LSB + n * CT_STRIDE +: 2]);
  endfunction

  function automatic bmu_span_t span_of(logic [31:0] c, int n);
    return bmu_span_t'(c[CT_SIZE_LSB + n * CT_STRIDE +: 2]);
  endfunction
endpackage

/* File: logic/bmu_cmp.sv */
// breakpoint match unit: one address comparator
`timescale 1ns/100ps
`default_nettype none
module bmu_cmp #(
  parameter int unsigned AW = 32,
  parameter bit EIGHT = 1'b0
) (
  // breakpoint setup
  input wire logic [AW-1:0] base_i,
  input wire bmu_pkg::bmu_kind_t kind_i,
  input wire bmu_pkg::bmu_span_t span_i,
  input wire logic ext_i,
  input wire logic resume_i,
  // core accesses
  input wire logic fetch_v_i,
  input wire logic [AW-1:0] fetch_addr_i,
  input wire logic data_v_i,
  input wire logic data_wr_i,
  input wire logic [AW-1:0] data_addr_i,
  input wire logic [bmu_pkg::NB_W-1:0] data_nb_i,
  input wire logic io_v_i,
  input wire logic [bmu_pkg::IO_W-1:0] io_port_i,
  input wire logic [bmu_pkg::NB_W-1:0] io_nb_i,
  // result
  output logic hit_o
);
  import bmu_pkg::*;

  logic [2:0] lowmask;
  logic [3:0] len;
  logic span_ok;
  logic [AW-1:0] lo;
  logic [AW-1:0] io_addr;

  // any byte of [a, a+n-1] inside [lo, lo+l-1]
  function automatic logic overlap(logic [AW-1:0] a, logic [3:0] n,
                                   logic [AW-1:0] b, logic [3:0] l);
    logic [AW:0] a_end;
    logic [AW:0] b_end;
    a_end = {1'b0, a} + {{(AW-3){1'b0}}, n} - {{AW{1'b0}}, 1'b1};
    b_end = {1'b0, b} + {{(AW-3){1'b0}}, l} - {{AW{1'b0}}, 1'b1};
    return (n != 4'h0) && ({1'b0, a} <= b_end) && (a_end >= {1'b0, b});
  endfunction

  always_comb begin
    unique case (span_i)
      SPAN_1: begin
        lowmask = 3'h0; len = 4'h1; span_ok = 1'b1;
      end
      SPAN_2: begin
        lowmask = 3'h1; len = 4'h2; span_ok = 1'b1;
      end
      SPAN_4: begin
        lowmask = 3'h3; len = 4'h4; span_ok = 1'b1;
      end
      SPAN_8: begin
        // without the option the encoding never matches a data or io access
        lowmask = 3'h7; len = 4'h8; span_ok = EIGHT;
      end
    endcase
  end

  assign lo = base_i & ~{{(AW-3){1'b0}}, lowmask};
  assign io_addr = {{(AW-IO_W){1'b0}}, io_port_i};

  always_comb begin
    unique case (kind_i)
      // exact compare: only the first byte, size must be 1; other sizes clear the low base bits before the compare
      KIND_EXEC: hit_o = fetch_v_i && !resume_i
                         && fetch_addr_i == lo;
      KIND_WR: hit_o = span_ok && data_v_i && data_wr_i
                       && overlap(data_addr_i, data_nb_i, lo, len);
      // undefined without extensions: never matches
      KIND_IO: hit_o = span_ok && ext_i && io_v_i
                       && overlap(io_addr, io_nb_i, lo, len);
      KIND_RW: hit_o = span_ok && data_v_i
                       && overlap(data_addr_i, data_nb_i, lo, len);
    endcase
  end
endmodule
`default_nettype wire

/* File: test/bmu_core_model.sv */
// core pipeline model: drives fetch, data and io accesses into the unit
`timescale 1ns/100ps
`default_nettype none
module bmu_core_model (
  // clock
  input wire logic mclk_i,
  // fetch
  output logic fetch_valid_o,
  output logic [31:0] fetch_addr_o,
  // data
  output logic data_valid_o,
  output logic data_write_o,
  output logic [31:0] data_addr_o,
  output logic [3:0] data_nbytes_o,
  // io
  output logic io_valid_o,
  output logic [15:0] io_port_o,
  output logic [3:0] io_nbytes_o
);
  initial begin
    {fetch_valid_o, data_valid_o, io_valid_o, data_write_o} = 4'h0;
    {fetch_addr_o, data_addr_o, io_port_o} = 80'h0;
    {data_nbytes_o, io_nbytes_o} = 8'h00;
  end
  // address is the first byte, first prefix when prefixed
  task automatic fetch(input logic [31:0] a);
    @(posedge mclk_i);
    fetch_valid_o <= 1'b1;
    fetch_addr_o <= a;
    @(negedge mclk_i);
  endtask
  task automatic data(input logic w, input logic [31:0] a,
                      input logic [3:0] n);
    @(posedge mclk_i);
    data_valid_o <= 1'b1;
    data_write_o <= w;
    data_addr_o <= a;
    data_nbytes_o <= n;
    @(negedge mclk_i);
  endtask
  task automatic io(input logic [15:0] p, input logic [3:0] n);
    @(posedge mclk_i);
    io_valid_o <= 1'b1;
    io_port_o <= p;
    io_nbytes_o <= n;
    @(negedge mclk_i);
  endtask
  // released lines flip so a stale value can never still match
  task automatic idle;
    @(posedge mclk_i);
    {fetch_valid_o, data_valid_o, io_valid_o} <= 3'h0;
    fetch_addr_o <= ~fetch_addr_o;
    data_addr_o <= ~data_addr_o;
    data_nbytes_o <= 4'h0;
    io_port_o <= ~io_port_o;
    io_nbytes_o <= 4'h0;
    #1;
  endtask
endmodule
`default_nettype wire

/* File: test/breakpoint_match_unit_test.sv */
// breakpoint match unit: self-checking testbench
`timescale 1ns/100ps
`default_nettype none
module breakpoint_match_unit_test;
  logic mclk_i, rstn_i, dr_wr_i, dr_rd_i, ext, rf, step, mov, done;
  logic tsw, ttrap, hent, dr_undef_o, fault_req_o, trap_req_o, fv, dv, dw, iv;
  logic [2:0] dr_sel_i;
  logic [31:0] dr_wdata_i, dr_rdata_o, brk_status_word_o;
  logic [31:0] brk_control_word_o, fa, da, r;
  logic [3:0] brk_hit_flags_o, dn, inb;
  logic [15:0] ip;
  int mismatches, checks;
  bmu_core_model i_core (.mclk_i(mclk_i), .fetch_valid_o(fv),
    .fetch_addr_o(fa), .data_valid_o(dv), .data_write_o(dw),
    .data_addr_o(da), .data_nbytes_o(dn), .io_valid_o(iv),
    .io_port_o(ip), .io_nbytes_o(inb));
  bmu_top #(.EIGHT_BYTE(1'b0)) i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .dr_sel_i(dr_sel_i), .dr_wr_i(dr_wr_i), .dr_rd_i(dr_rd_i),
    .dr_wdata_i(dr_wdata_i), .dr_rdata_o(dr_rdata_o),
    .dr_undef_o(dr_undef_o), .ext_interp_flag_i(ext),
    .resume_flag_i(rf), .step_trap_flag_i(step), .fetch_valid_i(fv),
    .fetch_addr_i(fa), .data_valid_i(dv), .data_write_i(dw),
    .data_addr_i(da), .data_nbytes_i(dn), .io_valid_i(iv),
    .io_port_i(ip), .io_nbytes_i(inb), .mov_dr_i(mov),
    .insn_done_i(done), .task_switch_i(tsw), .task_trap_i(ttrap),
    .handler_entry_i(hent), .brk_hit_flags_o(brk_hit_flags_o),
    .fault_req_o(fault_req_o), .trap_req_o(trap_req_o),
    .brk_status_word_o(brk_status_word_o),
    .brk_control_word_o(brk_control_word_o));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    @(posedge mclk_i);
    dr_sel_i <= s;
    dr_wr_i <= 1'b1;
    dr_wdata_i <= d;
    @(posedge mclk_i);
    dr_wr_i <= 1'b0;
    dr_wdata_i <= ~d;
    #1;
  endtask
  task automatic rd(input logic [2:0] s);
    @(posedge mclk_i);
    dr_sel_i <= s;
    dr_rd_i <= 1'b1;
    @(posedge mclk_i);
    dr_rd_i <= 1'b0;
    #1 r = dr_rdata_o;
  endtask
  // outputs of one access, then status sampled at the following edge
  task automatic judge(input logic [3:0] h, input logic f, input logic t);
    logic [31:0] old;
    old = brk_status_word_o;
    check(brk_hit_flags_o, h);
    check({fault_req_o, trap_req_o}, {f, t});
    i_core.idle;
    check(brk_status_word_o[3:0], (f | t) ? h : old[3:0]);
  endtask
  task automatic t_regs;
    rd(7);
    check(r, 32'h0);
    check(brk_status_word_o, 32'h0);
    wr(7, 32'hFFFFDFFF);
    check(brk_control_word_o, 32'hFFFF03FF);
    wr(6, 32'hFFFFFFFF);
    rd(4);
    check(r, 32'h0000E00F);
    wr(0, 32'h12345678);
    rd(0);
    check(r, 32'h12345678);
    @(posedge mclk_i);
    {ext, dr_sel_i, dr_rd_i} <= {1'b1, 3'h5, 1'b1};
    @(negedge mclk_i);
    check(dr_undef_o, 1'b1);
    @(posedge mclk_i);
    {ext, dr_rd_i} <= 2'b00;
    wr(6, 32'h0);
    wr(7, 32'h0);
  endtask
  // four data breakpoints, all armed for every task
  task automatic t_table;
    wr(0, 32'h000A0001);
    wr(1, 32'h000A0002);
    wr(2, 32'h000B0002);
    wr(3, 32'h000C0000);
    wr(7, 32'hD71300AA);
    i_core.data(0, 32'hA0001, 1); judge(4'h1, 0, 1);
    i_core.data(1, 32'hA0001, 2); judge(4'h3, 0, 1);
    i_core.data(1, 32'hA0002, 1); judge(4'h2, 0, 1);
    i_core.data(1, 32'hA0002, 2); judge(4'h2, 0, 1);
    i_core.data(0, 32'hB0001, 4); judge(4'h4, 0, 1);
    i_core.data(1, 32'hC0001, 2); judge(4'h8, 0, 1);
    i_core.data(1, 32'hC0003, 1); judge(4'h8, 0, 1);
    i_core.data(0, 32'hA0000, 1); judge(4'h0, 0, 0);
    i_core.data(0, 32'hA0002, 1); judge(4'h0, 0, 0);
    i_core.data(1, 32'hC0004, 4); judge(4'h0, 0, 0);
    i_core.data(1, 32'hB0000, 2); judge(4'h0, 0, 0);
    wr(3, 32'h000C0002);
    i_core.data(1, 32'hC0000, 1); judge(4'h8, 0, 1);
  endtask
  task automatic t_kinds;
    wr(7, 32'h00000002);
    wr(0, 32'h00001000);
    i_core.fetch(32'h1000); judge(4'h1, 1, 0);
    i_core.fetch(32'h1001); judge(4'h0, 0, 0);
    rf <= 1'b1;
    i_core.fetch(32'h1000); judge(4'h0, 0, 0);
    rf <= 1'b0;
    wr(0, 32'h000003F8);
    wr(7, 32'h00020002);
    ext <= 1'b1;
    i_core.io(16'h03F8, 1); judge(4'h1, 0, 1);
    wr(0, 32'h000103F8);
    i_core.io(16'h03F8, 1); judge(4'h0, 0, 0);
    wr(0, 32'h000003F8);
    ext <= 1'b0;
    i_core.io(16'h03F8, 1); judge(4'h0, 0, 0);
    wr(0, 32'h00002000);
    wr(7, 32'h000B0002);
    i_core.data(0, 32'h2004, 1); judge(4'h0, 0, 0);
  endtask
  task automatic t_arms;
    wr(0, 32'h00005000);
    wr(7, 32'h00030001);
    i_core.data(1, 32'h5000, 1); judge(4'h1, 0, 1);
    // handler view: only the armed breakpoint's flag is trusted
    rd(6);
    check(r[3:0] & 4'h1, 4'h1);
    wr(7, 32'h00030003);
    @(posedge mclk_i);
    {tsw, ttrap} <= 2'b11;
    @(negedge mclk_i);
    check(trap_req_o, 1'b1);
    @(posedge mclk_i);
    {tsw, ttrap} <= 2'b00;
    #1 check(brk_control_word_o, 32'h00030002);
    check(brk_status_word_o[15], 1'b1);
    wr(7, 32'h00030000);
    i_core.data(1, 32'h5000, 1); judge(4'h1, 0, 0);
    @(posedge mclk_i);
    {step, done} <= 2'b11;
    @(negedge mclk_i);
    check(trap_req_o, 1'b1);
    @(posedge mclk_i);
    {step, done} <= 2'b00;
    #1 check(brk_status_word_o[15:14], 2'b11);
    wr(7, 32'h00002000);
    @(posedge mclk_i);
    mov <= 1'b1;
    @(negedge mclk_i);
    check(fault_req_o, 1'b1);
    @(posedge mclk_i);
    mov <= 1'b0;
    #1 check(brk_status_word_o[15:13], 3'b111);
    wr(7, 32'h0);
    check(brk_control_word_o, 32'h00002000);
    @(posedge mclk_i);
    hent <= 1'b1;
    @(posedge mclk_i);
    hent <= 1'b0;
    #1 check(brk_control_word_o, 32'h0);
    wr(6, 32'h0);
    check(brk_status_word_o, 32'h0);
  endtask
  initial begin
    {rstn_i, dr_wr_i, dr_rd_i, ext, rf, step, mov, done} = 8'h00;
    {tsw, ttrap, hent, dr_sel_i, dr_wdata_i} = 38'h0;
    mismatches = 0;
    checks = 0;
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_regs;
    t_table;
    t_kinds;
    t_arms;
    summarize;
  end
  // far beyond the 130 or so cycles the tests need
  initial begin
    #100000;
    mismatches++;
    summarize;
  end
endmodule
`default_nettype wire
